//--- inc/throttle_pkg.sv
// Package holding constants and carriers for the ownership throttle block
package throttle_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  localparam int TICK_PERIOD_NS = 50;
  localparam int TICK_DIV = (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [1:0] TICK_DIV_LAST = 2'(TICK_DIV - 1);

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_HMT_LOAD = 8'h04;
  localparam logic [7:0] ADDR_SMT_LOAD = 8'h08;
  localparam logic [7:0] ADDR_HST_LOAD = 8'h0C;
  localparam logic [7:0] ADDR_HMW_LOAD = 8'h10;
  localparam logic [7:0] ADDR_HSW_LOAD = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h18;
  localparam logic [7:0] ADDR_COUNT_A = 8'h1C;
  localparam logic [7:0] ADDR_COUNT_B = 8'h20;

  // Control fields
  localparam int CTRL_CONCURRENT_BIT = 0;

  // Reset values
  localparam logic [7:0] LOAD_RESET = 8'hFF;
  localparam logic [7:0] WATCHDOG_RESET = 8'h10;
  localparam logic [31:0] CONTROL_RESET = 32'h0000_0001;
  localparam logic [7:0] COUNT_ZERO = 8'h00;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] host_memory_throttle;
    logic [7:0] system_memory_throttle;
    logic [7:0] host_system_throttle;
    logic [7:0] hmw;
    logic [7:0] hsw;
    logic concurrent;
  } settings_t;

  typedef struct packed {
    logic [7:0] host_memory_throttle;
    logic [7:0] system_memory_throttle;
    logic [7:0] host_system_throttle;
    logic [7:0] hmw;
    logic [7:0] hsw;
  } counts_t;

endpackage

//--- hdl/countdown8.sv
// Eight-bit reloadable down-counter advanced by a shared tick
`timescale 1ns/1ps
module countdown8
  import throttle_pkg::*;
(
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_b,
  // Control
  input wire logic i_load,
  input wire logic [7:0] i_value,
  input wire logic i_tick,
  input wire logic i_hold,
  input wire logic i_stop,
  // State
  output logic o_running,
  output logic o_expired,
  output logic [7:0] o_count
);

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_running <= 1'b0;
      o_count <= COUNT_ZERO;
    end else if (i_stop) begin
      o_running <= 1'b0;
    end else if (i_load) begin
      o_running <= (i_value != COUNT_ZERO);
      o_count <= i_value;
    end else if (o_running && i_tick && !i_hold) begin
      o_count <= o_count - 8'h01;
      if (o_count == 8'h01) begin
        o_running <= 1'b0;
      end
    end
  end

  // One-cycle pulse when the count runs out
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_expired <= 1'b0;
    end else begin
      o_expired <= !i_stop && !i_load && o_running && i_tick && !i_hold &&
                   (o_count == 8'h01);
    end
  end

endmodule // countdown8

//--- hdl/ownership_throttle_watchdog.sv
// Memory and system-bus ownership throttles with idle watchdogs
//
// The implementer's own choices: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
// What this block does
// - Each throttle is an 8-bit down-counter ticking every 50 ns.
// - Count starts at ownership; foreign requests honoured only after zero.
// - A locked cycle keeps the request window shut.
// - Watchdog expiry does nothing when nobody else requests the resource.
// - Host-memory throttle only in concurrent mode after forced takeover.
// - Memory-ready held low to EISA masters while host throttle runs.
// - Host-memory counter loads on takeover, counts to zero, then expires.
// - Memory ownership request blocked during host throttle, released after.
// - Host-memory watchdog reloads at host cycle end, counts while idle.
// - Host-memory watchdog expiry ends throttle, memory back to system.
// - New host cycle reloads host-memory watchdog; countdown resumes later.
// - Aborted cache-hit host cycle reloads host-memory watchdog only at its start.
// - System-memory throttle guards EISA ownership, concurrent mode only.
// - At system throttle expiry, give memory to pending host or refresh.
// - Memory taken for a pending host by dropping memory-ready on next main-memory cycle.
// - System throttle expiry during EISA burst is ignored.
// - Host-system throttle masks system hold request in both modes.
// - Host-system throttle starts once, on system hold request falling.
// - Host-system watchdog reload per host access; expiry unmasks hold.
// - Concurrent: system accesses reload; otherwise memory or system ones.
// - Aborted cache-hit host cycle does not reload host-system watchdog.
module ownership_throttle_watchdog
  import throttle_pkg::*;
(
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_b,
  // AXI4-Lite write address and data
  input wire logic [7:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  // AXI4-Lite write response
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  // AXI4-Lite read
  input wire logic [7:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  // Host side
  input wire logic i_host_cycle_qualifier_n,
  input wire logic i_host_cycle_end,
  input wire logic i_host_cycle_to_system,
  input wire logic i_host_strobe,
  input wire logic i_memory_ownership_ack,
  input wire logic i_locked,
  input wire logic i_refresh_request,
  output logic o_memory_ownership_request,
  // System side
  input wire logic i_system_mem_request,
  input wire logic i_system_owns_memory,
  input wire logic i_eisa_master,
  input wire logic i_eisa_burst,
  input wire logic i_system_next_to_memory,
  input wire logic i_system_hold_request,
  output logic o_memory_ready_out,
  output logic o_hold_request_masked,
  output logic o_take_memory,
  output logic o_give_refresh
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  localparam int NSYNC = 14;
  logic [NSYNC-1:0] pin_raw;
  logic [NSYNC-1:0] sync_a_reg;
  logic [NSYNC-1:0] sync_b_reg;

  assign pin_raw = {i_host_cycle_qualifier_n, i_host_cycle_end,
                    i_host_cycle_to_system, i_host_strobe,
                    i_memory_ownership_ack, i_locked, i_refresh_request,
                    i_system_mem_request, i_system_owns_memory,
                    i_eisa_master, i_eisa_burst, i_system_next_to_memory,
                    i_system_hold_request, 1'b0};

  // Qualifier idles high, so no false cycle start follows reset
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sync_a_reg <= {1'b1, {(NSYNC-1){1'b0}}};
      sync_b_reg <= {1'b1, {(NSYNC-1){1'b0}}};
    end else begin
      sync_a_reg <= pin_raw;
      sync_b_reg <= sync_a_reg;
    end
  end

  logic qual_n, cyc_end, cyc_sys, hstrobe, mack, locked, refresh;
  logic sys_req, sys_owns, eisa, burst, next_mem, system_hold_request;
  assign {qual_n, cyc_end, cyc_sys, hstrobe, mack, locked, refresh,
          sys_req, sys_owns, eisa, burst, next_mem, system_hold_request} =
          sync_b_reg[NSYNC-1:1];

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  settings_t set_reg;
  counts_t counts;
  logic [31:0] control_reg;
  logic [7:0] aw_addr_reg;
  logic aw_full_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic w_full_reg;
  logic hmt_run, smt_run, hst_run, hmw_run, hsw_run;

  function automatic logic [7:0] merge8(input logic [7:0] old,
                                        input logic [31:0] data,
                                        input logic strb);
    return strb ? data[7:0] : old;
  endfunction

  function automatic logic mapped(input logic [7:0] addr);
    return (addr <= ADDR_COUNT_B) && (addr[1:0] == 2'b00);
  endfunction

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      aw_full_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_full_reg <= 1'b0;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
    end else begin
      if (i_awvalid && o_awready) begin
        aw_full_reg <= 1'b1;
        aw_addr_reg <= i_awaddr;
      end else if (o_bvalid && i_bready) begin
        aw_full_reg <= 1'b0;
      end
      if (i_wvalid && o_wready) begin
        w_full_reg <= 1'b1;
        w_data_reg <= i_wdata;
        w_strb_reg <= i_wstrb;
      end else if (o_bvalid && i_bready) begin
        w_full_reg <= 1'b0;
      end
    end
  end

  logic do_write;
  assign do_write = aw_full_reg && w_full_reg && !o_bvalid;

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_awready <= 1'b0;
      o_wready <= 1'b0;
      o_bvalid <= 1'b0;
      o_bresp <= RESP_OKAY;
    end else begin
      o_awready <= !aw_full_reg && !(i_awvalid && o_awready);
      o_wready <= !w_full_reg && !(i_wvalid && o_wready);
      if (do_write) begin
        o_bvalid <= 1'b1;
        o_bresp <= mapped(aw_addr_reg) ? RESP_OKAY : RESP_SLVERR;
      end else if (i_bready) begin
        o_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      control_reg <= CONTROL_RESET;
      set_reg.concurrent <= CONTROL_RESET[CTRL_CONCURRENT_BIT];
      set_reg.host_memory_throttle <= LOAD_RESET;
      set_reg.system_memory_throttle <= LOAD_RESET;
      set_reg.host_system_throttle <= LOAD_RESET;
      set_reg.hmw <= WATCHDOG_RESET;
      set_reg.hsw <= WATCHDOG_RESET;
    end else if (do_write) begin
      case (aw_addr_reg)
        ADDR_CONTROL: begin
          control_reg[0] <= w_strb_reg[0] ? w_data_reg[0] : control_reg[0];
          set_reg.concurrent <= w_strb_reg[0] ? w_data_reg[0] :
                                control_reg[0];
        end
        ADDR_HMT_LOAD: set_reg.host_memory_throttle <= merge8(set_reg.host_memory_throttle, w_data_reg,
                                             w_strb_reg[0]);
        ADDR_SMT_LOAD: set_reg.system_memory_throttle <= merge8(set_reg.system_memory_throttle, w_data_reg,
                                             w_strb_reg[0]);
        ADDR_HST_LOAD: set_reg.host_system_throttle <= merge8(set_reg.host_system_throttle, w_data_reg,
                                             w_strb_reg[0]);
        ADDR_HMW_LOAD: set_reg.hmw <= merge8(set_reg.hmw, w_data_reg,
                                             w_strb_reg[0]);
        ADDR_HSW_LOAD: set_reg.hsw <= merge8(set_reg.hsw, w_data_reg,
                                             w_strb_reg[0]);
        default: ;
      endcase
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_arready <= 1'b0;
      o_rvalid <= 1'b0;
      o_rdata <= 32'h0000_0000;
      o_rresp <= RESP_OKAY;
    end else begin
      o_arready <= !o_rvalid && !(i_arvalid && o_arready);
      if (i_arvalid && o_arready) begin
        o_rvalid <= 1'b1;
        o_rresp <= mapped(i_araddr) ? RESP_OKAY : RESP_SLVERR;
        case (i_araddr)
          ADDR_CONTROL: o_rdata <= {31'h0, control_reg[0]};
          ADDR_HMT_LOAD: o_rdata <= {24'h0, set_reg.host_memory_throttle};
          ADDR_SMT_LOAD: o_rdata <= {24'h0, set_reg.system_memory_throttle};
          ADDR_HST_LOAD: o_rdata <= {24'h0, set_reg.host_system_throttle};
          ADDR_HMW_LOAD: o_rdata <= {24'h0, set_reg.hmw};
          ADDR_HSW_LOAD: o_rdata <= {24'h0, set_reg.hsw};
          ADDR_STATUS: o_rdata <= {27'h0, hsw_run, hmw_run, hst_run,
                                   smt_run, hmt_run};
          ADDR_COUNT_A: o_rdata <= {8'h0, counts.host_system_throttle, counts.system_memory_throttle,
                                    counts.host_memory_throttle};
          ADDR_COUNT_B: o_rdata <= {16'h0, counts.hsw, counts.hmw};
          default: o_rdata <= 32'h0000_0000;
        endcase
      end else if (i_rready) begin
        o_rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Timebase
  // ----------------------------------------------------------------
  logic [1:0] div_reg;
  logic tick;
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      div_reg <= 2'b00;
    end else begin
      div_reg <= (div_reg == TICK_DIV_LAST) ? 2'b00 : div_reg + 2'b01;
    end
  end
  assign tick = (div_reg == TICK_DIV_LAST);

  // ----------------------------------------------------------------
  // Event decode
  // ----------------------------------------------------------------
  logic sys_owns_d_reg, system_hold_request_d_reg, qual_d_reg;
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sys_owns_d_reg <= 1'b0;
      system_hold_request_d_reg <= 1'b0;
      qual_d_reg <= 1'b1;
    end else begin
      sys_owns_d_reg <= sys_owns;
      system_hold_request_d_reg <= system_hold_request;
      qual_d_reg <= qual_n;
    end
  end

  logic conc, eisa_owns, eisa_start, host_pending, host_start, host_end;
  logic hmt_exp, smt_exp, hst_exp, hmw_exp, hsw_exp;
  logic smt_take, hmt_start, hmw_load, hsw_load, hst_start, hst_stop;
  logic hmt_stop;

  assign conc = set_reg.concurrent;
  assign eisa_owns = sys_owns && eisa && conc;
  assign eisa_start = eisa_owns && !sys_owns_d_reg;
  assign host_pending = hstrobe && mack;
  // Qualifier edge starts a host cycle; a rising edge mid-cycle is an abort
  assign host_start = qual_d_reg && !qual_n;
  assign host_end = cyc_end && !qual_n;
  // Window opens at expiry unless locked or mid-burst
  assign smt_take = smt_exp && sys_owns && !locked && !burst &&
                    (host_pending || refresh);
  assign hmt_start = smt_take && host_pending;
  assign hmt_stop = (hmw_exp && sys_req) || !conc;
  assign hmw_load = hmt_run && (host_end || host_start);
  assign hsw_load = hst_run && host_end &&
                    (cyc_sys || !conc);
  assign hst_start = system_hold_request_d_reg && !system_hold_request;
  assign hst_stop = hsw_exp && system_hold_request;

  // ----------------------------------------------------------------
  // Counters
  // ----------------------------------------------------------------
  countdown8 u_hmt (
    .i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_load(hmt_start),
    .i_value(set_reg.host_memory_throttle), .i_tick(tick), .i_hold(1'b0),
    .i_stop(hmt_stop), .o_running(hmt_run), .o_expired(hmt_exp),
    .o_count(counts.host_memory_throttle)
  );
  countdown8 u_smt (
    .i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_load(eisa_start),
    .i_value(set_reg.system_memory_throttle), .i_tick(tick), .i_hold(1'b0),
    .i_stop(!eisa_owns), .o_running(smt_run), .o_expired(smt_exp),
    .o_count(counts.system_memory_throttle)
  );
  countdown8 u_hst (
    .i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_load(hst_start),
    .i_value(set_reg.host_system_throttle), .i_tick(tick), .i_hold(1'b0),
    .i_stop(hst_stop), .o_running(hst_run), .o_expired(hst_exp),
    .o_count(counts.host_system_throttle)
  );
  countdown8 u_hmw (
    .i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_load(hmw_load || hmt_start),
    .i_value(set_reg.hmw), .i_tick(tick), .i_hold(!qual_n),
    .i_stop(!hmt_run && !hmt_start), .o_running(hmw_run),
    .o_expired(hmw_exp), .o_count(counts.hmw)
  );
  countdown8 u_hsw (
    .i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_load(hsw_load || hst_start),
    .i_value(set_reg.hsw), .i_tick(tick), .i_hold(1'b0),
    .i_stop(!hst_run && !hst_start), .o_running(hsw_run),
    .o_expired(hsw_exp), .o_count(counts.hsw)
  );

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_memory_ownership_request <= 1'b0;
      o_memory_ready_out <= 1'b1;
      o_hold_request_masked <= 1'b0;
      o_take_memory <= 1'b0;
      o_give_refresh <= 1'b0;
    end else begin
      o_memory_ownership_request <= sys_req && !hmt_run && !hmt_start;
      o_memory_ready_out <= !((hmt_run || hmt_start) && eisa &&
                              next_mem);
      o_hold_request_masked <= hst_run || hst_start;
      o_take_memory <= smt_take;
      o_give_refresh <= smt_take && !host_pending && refresh;
    end
  end

  logic unused_ok;
  assign unused_ok = hmt_exp ^ hst_exp ^ (|control_reg[31:1]) ^
                     (|w_data_reg[31:8]) ^ (|w_strb_reg[3:1]);

endmodule // ownership_throttle_watchdog

//--- verification/host_owner_model.sv
// Host ownership logic answering the memory ownership request
`timescale 1ns/1ps
module host_owner_model (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_b,
  // Request in, grant state out
  input wire logic i_request,
  input wire logic [3:0] i_delay,
  output logic o_ack
);
  logic [3:0] wait_reg;

  // Host keeps memory until a request has waited i_delay cycles
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wait_reg <= 4'h0;
      o_ack <= 1'b1;
    end else if (!i_request) begin
      wait_reg <= 4'h0;
      o_ack <= 1'b1;
    end else if (wait_reg >= i_delay) begin
      o_ack <= 1'b0;
    end else begin
      wait_reg <= wait_reg + 4'h1;
    end
  end
endmodule // host_owner_model

//--- verification/otw_checker.sv
// Concurrent assertions on the ownership throttle block ports
`timescale 1ns/1ps
module otw_checker (
  // Inputs watched
  input wire logic i_mclk,
  input wire logic i_rst_b,
  input wire logic i_bready,
  input wire logic i_rready,
  input wire logic i_host_strobe,
  input wire logic i_memory_ownership_ack,
  input wire logic i_refresh_request,
  input wire logic i_system_mem_request,
  input wire logic i_eisa_master,
  input wire logic i_eisa_burst,
  input wire logic i_system_next_to_memory,
  input wire logic i_system_hold_request,
  // Outputs watched
  input wire logic [1:0] o_bresp,
  input wire logic o_bvalid,
  input wire logic o_rvalid,
  input wire logic o_memory_ownership_request,
  input wire logic o_memory_ready_out,
  input wire logic o_hold_request_masked,
  input wire logic o_take_memory
);
  logic [7:0] low_h;
  logic [7:0] req_h;
  logic [7:0] mem_h;
  logic [7:0] pend_h;
  logic [7:0] burst_h;

  // Recent history of the causes, covering the pin latency
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      low_h <= 8'h00;
      req_h <= 8'h00;
      mem_h <= 8'h00;
      pend_h <= 8'h00;
      burst_h <= 8'h00;
    end else begin
      low_h <= {low_h[6:0], !i_system_hold_request};
      req_h <= {req_h[6:0], i_system_mem_request};
      mem_h <= {mem_h[6:0], i_eisa_master && i_system_next_to_memory};
      pend_h <= {pend_h[6:0], (i_host_strobe && i_memory_ownership_ack)
                 || i_refresh_request};
      burst_h <= {burst_h[6:0], i_eisa_burst};
    end
  end

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_b);

  a_reset_idle: assert property ($rose(i_rst_b) |-> o_memory_ready_out
    && !o_hold_request_masked && !o_take_memory
    && !o_memory_ownership_request) else $error("outputs not idle");
  a_bvalid_holds: assert property (o_bvalid && !i_bready |=> o_bvalid)
    else $error("bvalid dropped early");
  a_bresp_stable: assert property (o_bvalid && !i_bready |=> $stable(o_bresp))
    else $error("bresp changed while waiting");
  a_rvalid_holds: assert property (o_rvalid && !i_rready |=> o_rvalid)
    else $error("rvalid dropped early");
  a_mask_cause: assert property ($rose(o_hold_request_masked) |-> |low_h)
    else $error("hold masked without hold falling");
  a_req_cause: assert property ($rose(o_memory_ownership_request) |-> |req_h)
    else $error("ownership request without system request");
  a_ready_cause: assert property ($fell(o_memory_ready_out) |-> |mem_h)
    else $error("memory ready dropped without master access");
  a_take_cause: assert property ($rose(o_take_memory) |-> |pend_h)
    else $error("memory taken with nothing pending");
  a_burst_keeps: assert property (&burst_h |-> !$rose(o_take_memory))
    else $error("memory taken during burst");

  cover property ($rose(o_hold_request_masked));
  cover property ($rose(o_take_memory));
  cover property ($fell(o_memory_ready_out));
endmodule // otw_checker

bind ownership_throttle_watchdog otw_checker u_chk (
  .i_mclk(i_mclk),
  .i_rst_b(i_rst_b),
  .i_bready(i_bready),
  .i_rready(i_rready),
  .i_host_strobe(i_host_strobe),
  .i_memory_ownership_ack(i_memory_ownership_ack),
  .i_refresh_request(i_refresh_request),
  .i_system_mem_request(i_system_mem_request),
  .i_eisa_master(i_eisa_master),
  .i_eisa_burst(i_eisa_burst),
  .i_system_next_to_memory(i_system_next_to_memory),
  .i_system_hold_request(i_system_hold_request),
  .o_bresp(o_bresp),
  .o_bvalid(o_bvalid),
  .o_rvalid(o_rvalid),
  .o_memory_ownership_request(o_memory_ownership_request),
  .o_memory_ready_out(o_memory_ready_out),
  .o_hold_request_masked(o_hold_request_masked),
  .o_take_memory(o_take_memory)
);

//--- verification/test_ownership_throttle_watchdog.sv
// Self-checking bench for the ownership throttle block
`timescale 1ns/1ps
module test_ownership_throttle_watchdog
  import throttle_pkg::*;
();
  logic i_mclk, i_rst_b, awv, wv, bry, arv, rry;
  logic [7:0] awa, ara;
  logic [31:0] wd;
  logic qn, cend, tosys, stb, lck, rfr, sreq, sown, eisa, bst, nmem, shd;
  logic [3:0] pdly;
  logic awr, wr, bv, arr, rv, ack, req, rdy, msk, take, grf;
  logic [1:0] br, rr;
  logic [31:0] rd;
  logic [4:0] mon;
  int fails = 0;
  int tests_run = 0;
  int n;
  assign mon = {rdy, grf, take, msk, req};

  initial begin
    i_mclk = 1'b0;
    forever #12.5 i_mclk = ~i_mclk;
  end

  ownership_throttle_watchdog DUT (.i_mclk(i_mclk), .i_rst_b(i_rst_b),
    .i_awaddr(awa), .i_awvalid(awv), .o_awready(awr), .i_wdata(wd),
    .i_wstrb(4'hF), .i_wvalid(wv), .o_wready(wr), .o_bresp(br),
    .o_bvalid(bv), .i_bready(bry), .i_araddr(ara), .i_arvalid(arv),
    .o_arready(arr), .o_rdata(rd), .o_rresp(rr), .o_rvalid(rv),
    .i_rready(rry), .i_host_cycle_qualifier_n(qn), .i_host_cycle_end(cend),
    .i_host_cycle_to_system(tosys), .i_host_strobe(stb),
    .i_memory_ownership_ack(ack), .i_locked(lck), .i_refresh_request(rfr),
    .o_memory_ownership_request(req), .i_system_mem_request(sreq),
    .i_system_owns_memory(sown), .i_eisa_master(eisa), .i_eisa_burst(bst),
    .i_system_next_to_memory(nmem), .i_system_hold_request(shd),
    .o_memory_ready_out(rdy), .o_hold_request_masked(msk),
    .o_take_memory(take), .o_give_refresh(grf));

  host_owner_model u_host (.i_mclk(i_mclk), .i_rst_b(i_rst_b),
    .i_request(req), .i_delay(pdly), .o_ack(ack));

  task automatic close_out();
    if (fails == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic check(string s, logic [31:0] seen, logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", s, exp, seen);
    end
  endtask

  task automatic give_up(int k);
    if (k >= 60) begin
      fails++;
      close_out();
    end
  endtask

  task automatic axi_write(logic [7:0] a, logic [31:0] d, logic [1:0] e);
    int k;
    k = 0;
    @(posedge i_mclk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    do begin
      @(posedge i_mclk);
      k++;
      if (awr) awv <= 1'b0;
      if (wr) wv <= 1'b0;
    end while (!((awr || !awv) && (wr || !wv)) && k < 60);
    while (bv !== 1'b1 && k < 60) begin
      @(posedge i_mclk);
      k++;
    end
    give_up(k);
    bry <= 1'b0;
    check("bresp", 32'(br), 32'(e));
  endtask

  task automatic axi_read(logic [7:0] a, logic [31:0] x, logic [1:0] e);
    int k;
    k = 0;
    @(posedge i_mclk);
    ara <= a;
    arv <= 1'b1;
    rry <= 1'b1;
    do begin
      @(posedge i_mclk);
      k++;
      if (arr) arv <= 1'b0;
    end while (arr !== 1'b1 && k < 60);
    do begin
      @(posedge i_mclk);
      k++;
    end while (rv !== 1'b1 && k < 60);
    give_up(k);
    rry <= 1'b0;
    check("rdata", rd, x);
    check("rresp", 32'(rr), 32'(e));
  endtask

  // Count falling clock edges until a monitored output reaches lvl
  task automatic wait_mon(int b, logic lvl, int lim);
    n = 0;
    do begin
      @(negedge i_mclk);
      n++;
    end while (mon[b] !== lvl && n < lim);
    give_up(n >= lim ? 60 : 0);
  endtask

  task automatic pins(logic s, logic o, logic h, logic q);
    @(posedge i_mclk);
    sreq <= s;
    sown <= o;
    shd <= h;
    bst <= q;
  endtask

  logic [7:0] ra [9] = '{ADDR_CONTROL, ADDR_HMT_LOAD, ADDR_SMT_LOAD,
    ADDR_HST_LOAD, ADDR_HMW_LOAD, ADDR_HSW_LOAD, ADDR_STATUS,
    ADDR_COUNT_A, ADDR_COUNT_B};
  logic [7:0] rv8 [9] = '{8'h01, LOAD_RESET, LOAD_RESET, LOAD_RESET,
    WATCHDOG_RESET, WATCHDOG_RESET, 8'h00, 8'h00, 8'h00};

  initial begin
    {i_rst_b, awv, wv, bry, arv, rry, stb, lck, rfr, sreq} = 10'h000;
    {cend, tosys, sown, eisa, bst, nmem} = 6'h00;
    {qn, shd, awa, ara, wd, pdly} = {2'b11, 16'h0000, 32'h0, 4'h1};
    repeat (20) @(posedge i_mclk);
    i_rst_b <= 1'b1;
    @(negedge i_mclk);
    check("idle", 32'(mon), 32'h10);
    for (int i = 0; i < 9; i++) begin
      axi_read(ra[i], 32'(rv8[i]), RESP_OKAY);
    end
    axi_write(8'h40, 32'h5, RESP_SLVERR);
    axi_read(8'h40, 32'h0, RESP_SLVERR);
    // Host-system throttle in non-concurrent mode, 4 ticks
    axi_write(ADDR_CONTROL, 32'h0, RESP_OKAY);
    axi_write(ADDR_HST_LOAD, 32'h4, RESP_OKAY);
    axi_read(ADDR_HST_LOAD, 32'h4, RESP_OKAY);
    pins(1'b0, 1'b0, 1'b0, 1'b0);
    wait_mon(1, 1'b1, 12);
    wait_mon(1, 1'b0, 20);
    check("hst_len", 32'(n >= 6 && n <= 10), 32'h1);
    // Watchdog cuts a long throttle when hold is requested
    axi_write(ADDR_CONTROL, 32'h1, RESP_OKAY);
    axi_write(ADDR_HST_LOAD, 32'hFF, RESP_OKAY);
    axi_write(ADDR_HSW_LOAD, 32'h3, RESP_OKAY);
    pins(1'b0, 1'b0, 1'b1, 1'b0);
    repeat (6) @(posedge i_mclk);
    pins(1'b0, 1'b0, 1'b0, 1'b0);
    wait_mon(1, 1'b1, 12);
    pins(1'b0, 1'b0, 1'b1, 1'b0);
    wait_mon(1, 1'b0, 40);
    // Watchdog with nobody requesting leaves the mask up
    axi_write(ADDR_HST_LOAD, 32'h14, RESP_OKAY);
    axi_write(ADDR_HSW_LOAD, 32'h2, RESP_OKAY);
    pins(1'b0, 1'b0, 1'b0, 1'b0);
    wait_mon(1, 1'b1, 12);
    repeat (20) @(negedge i_mclk);
    check("mask_kept", 32'(msk), 32'h1);
    wait_mon(1, 1'b0, 60);
    // Request passes while no host throttle runs
    pins(1'b1, 1'b0, 1'b1, 1'b0);
    wait_mon(0, 1'b1, 12);
    pins(1'b0, 1'b0, 1'b1, 1'b0);
    wait_mon(0, 1'b0, 12);
    // Throttle expiry during a burst, then a pending host cycle
    axi_write(ADDR_SMT_LOAD, 32'h3, RESP_OKAY);
    axi_write(ADDR_HMT_LOAD, 32'hA, RESP_OKAY);
    axi_write(ADDR_HMW_LOAD, 32'hFF, RESP_OKAY);
    pdly <= 4'h8;
    stb <= 1'b1;
    eisa <= 1'b1;
    nmem <= 1'b1;
    pins(1'b0, 1'b1, 1'b1, 1'b1);
    n = 0;
    repeat (24) begin
      @(negedge i_mclk);
      n += int'(take !== 1'b0);
    end
    check("burst_take", 32'(n), 32'h0);
    // Burst over: master regains memory, so the throttle restarts
    pins(1'b0, 1'b0, 1'b1, 1'b0);
    pins(1'b0, 1'b1, 1'b1, 1'b0);
    wait_mon(2, 1'b1, 24);
    wait_mon(4, 1'b0, 12);
    pins(1'b1, 1'b1, 1'b1, 1'b0);
    repeat (6) @(negedge i_mclk);
    check("req_blocked", 32'(req), 32'h0);
    wait_mon(0, 1'b1, 40);
    // Refresh request gets memory on the next expiry
    stb <= 1'b0;
    rfr <= 1'b1;
    pins(1'b0, 1'b0, 1'b1, 1'b0);
    repeat (8) @(posedge i_mclk);
    pins(1'b0, 1'b1, 1'b1, 1'b0);
    wait_mon(3, 1'b1, 40);
    close_out();
  end
endmodule // test_ownership_throttle_watchdog
